// *** slt_regs.vh ***
// Register offsets, field positions, reset values and counts of the link transmitter.
`ifndef SLT_REGS_VH
`define SLT_REGS_VH

`define SLT_CTRL_OFF      12'h000
`define SLT_STATUS_OFF    12'h004
`define SLT_PADCNT_OFF    12'h008

`define SLT_CTRL_BYPASS   0
`define SLT_CTRL_RST      32'h00000000

`define SLT_ST_RD         0
`define SLT_ST_PAD        1
`define SLT_ST_FOFF       2
`define SLT_ST_BYPASS     3

`define SLT_BITS_PER_CHAR 4'hA
`define SLT_RP_LOW_CYC    4'h6
`define SLT_K28_CODE      5'h1C

`endif

// *** slt_transmitter.v ***
// Serial link transmitter: byte capture, 8B/10B encoder, pad insertion, serialiser, APB.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "slt_regs.vh"

// Contract
// - capture only when a load enable low
// - read pulse low 60%, per byte, first enable
// - ten serial bits per write clock period
// - capture to line about twenty-one bits
// - data flag low encodes data characters
// - data flag high encodes special characters
// - special C0.7 sends a violation symbol
// - violation request replaces character with violation
// - bypass takes ten raw bits unencoded
// - next edge loads shifter, bit a first
// - no enable at edge sends K28.5 pad
// - bypass first pad disparity may be wrong
// - three pairs carry identical stream
// - force-off parks pairs A and B low
// - pair C ignores force-off
module slt_transmitter (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire        write_clock,
  input  wire        load_strobe_first_n,
  input  wire        load_gate_next_n,
  input  wire        char_kind_flag,
  input  wire        violation_send,
  input  wire [7:0]  byte_in,
  input  wire        optical_force_off,
  output reg         read_pulse_out,
  output reg         line_pair_a_p,
  output reg         line_pair_a_n,
  output reg         line_pair_b_p,
  output reg         line_pair_b_n,
  output reg         monitor_pair_c_p,
  output reg         monitor_pair_c_n
);

  // ---------------------------------------------------------------
  // Encoding functions
  // ---------------------------------------------------------------
  function [2:0] ones6;
    input [5:0] v;
    ones6 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]}
          + {2'h0, v[4]} + {2'h0, v[5]};
  endfunction

  // Six-bit group abcdei for negative running disparity, a in the top bit.
  function [5:0] tbl6;
    input [4:0] x;
    case (x)
      5'h00: tbl6 = 6'h27;
      5'h01: tbl6 = 6'h1D;
      5'h02: tbl6 = 6'h2D;
      5'h03: tbl6 = 6'h31;
      5'h04: tbl6 = 6'h35;
      5'h05: tbl6 = 6'h29;
      5'h06: tbl6 = 6'h19;
      5'h07: tbl6 = 6'h38;
      5'h08: tbl6 = 6'h39;
      5'h09: tbl6 = 6'h25;
      5'h0A: tbl6 = 6'h15;
      5'h0B: tbl6 = 6'h34;
      5'h0C: tbl6 = 6'h0D;
      5'h0D: tbl6 = 6'h2C;
      5'h0E: tbl6 = 6'h1C;
      5'h0F: tbl6 = 6'h17;
      5'h10: tbl6 = 6'h1B;
      5'h11: tbl6 = 6'h23;
      5'h12: tbl6 = 6'h13;
      5'h13: tbl6 = 6'h32;
      5'h14: tbl6 = 6'h0B;
      5'h15: tbl6 = 6'h2A;
      5'h16: tbl6 = 6'h1A;
      5'h17: tbl6 = 6'h3A;
      5'h18: tbl6 = 6'h33;
      5'h19: tbl6 = 6'h26;
      5'h1A: tbl6 = 6'h16;
      5'h1B: tbl6 = 6'h36;
      5'h1C: tbl6 = 6'h0E;
      5'h1D: tbl6 = 6'h2E;
      5'h1E: tbl6 = 6'h1E;
      default: tbl6 = 6'h2B;
    endcase
  endfunction

  // Four-bit group fghj for negative running disparity.
  function [3:0] tbl4;
    input [2:0] y;
    case (y)
      3'h0: tbl4 = 4'hB;
      3'h1: tbl4 = 4'h9;
      3'h2: tbl4 = 4'h5;
      3'h3: tbl4 = 4'hC;
      3'h4: tbl4 = 4'hD;
      3'h5: tbl4 = 4'hA;
      3'h6: tbl4 = 4'h6;
      default: tbl4 = 4'hE;
    endcase
  endfunction

  // Returns {new running disparity, ten-bit code}; rd high means positive.
  function [10:0] enc10;
    input [4:0] x;
    input [2:0] y;
    input       k;
    input       rd;
    reg   [5:0] six;
    reg   [3:0] four;
    reg         rd_mid;
    reg         alt7;
    begin
      six = (k && x == `SLT_K28_CODE) ? 6'h0F : tbl6(x);
      if (rd && (ones6(six) != 3'h3 || (!k && x == 5'h07)))
        six = ~six;
      rd_mid = (ones6(six) != 3'h3) ? ~rd : rd;
      alt7 = k || (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
               || (rd_mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E));
      four = (y == 3'h7 && alt7) ? 4'h7 : tbl4(y);
      // Balanced special groups other than y = 3 take the complement of the data form at negative disparity.
      if ((ones6({2'h0, four}) != 3'h2 || y == 3'h3) ? rd_mid : (k && !rd_mid))
        four = ~four;
      enc10 = {(ones6({2'h0, four}) != 3'h2) ? ~rd_mid : rd_mid, six, four};
    end
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  reg  [14:0] pin_meta;
  reg  [14:0] pin_sync;
  reg         wclk_prev;
  wire        wclk_s  = pin_sync[0];
  wire        ena_n_s = pin_sync[1];
  wire        enn_n_s = pin_sync[2];
  wire        kflag_s = pin_sync[3];
  wire        svs_s   = pin_sync[4];
  wire        foff_s  = pin_sync[5];
  wire [7:0]  byte_s  = pin_sync[13:6];
  wire        wclk_rise = wclk_s & ~wclk_prev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta  <= 15'h0007;
      pin_sync  <= 15'h0007;
      wclk_prev <= 1'b1;
    end else begin
      pin_meta  <= {1'b0, byte_in, optical_force_off, violation_send, char_kind_flag,
                    load_gate_next_n, load_strobe_first_n, write_clock};
      pin_sync  <= pin_meta;
      wclk_prev <= wclk_s;
    end
  end

  // ---------------------------------------------------------------
  // Control registers over APB
  // ---------------------------------------------------------------
  reg  [31:0] ctrl;
  reg  [15:0] pad_count;
  reg         run_disp;
  reg         pad_active;
  wire        bypass = ctrl[`SLT_CTRL_BYPASS];
  wire        acc    = psel & penable;
  wire        hit    = (paddr == `SLT_CTRL_OFF) || (paddr == `SLT_STATUS_OFF)
                       || (paddr == `SLT_PADCNT_OFF);

  // Every access completes in its first access cycle.
  assign pready = 1'b1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= `SLT_CTRL_RST;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & ~penable & ~hit;
      if (acc && pwrite && paddr == `SLT_CTRL_OFF)
        ctrl <= {31'h00000000, pwdata[`SLT_CTRL_BYPASS]};
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SLT_CTRL_OFF:   prdata <= ctrl;
          `SLT_STATUS_OFF: prdata <= {28'h0000000, bypass, foff_s, pad_active, run_disp};
          `SLT_PADCNT_OFF: prdata <= {16'h0000, pad_count};
          default:         prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Input register, encoder and shifter
  // ---------------------------------------------------------------
  reg  [9:0]  in_raw;
  reg  [7:0]  in_byte;
  reg         in_k;
  reg         in_viol;
  reg         in_pad;
  reg         in_bypass;
  reg  [9:0]  shifter;
  reg  [3:0]  phase;
  reg  [10:0] next_code;
  wire        load_en = ~ena_n_s | ~enn_n_s;

  always @* begin
    next_code = {run_disp, 10'h000};
    if (in_pad) begin
      next_code = enc10(`SLT_K28_CODE, 3'h5, 1'b1, run_disp);
    end else if (in_bypass) begin
      next_code = {run_disp, in_raw};
    end else if (in_viol || (in_k && in_byte == 8'hE0)) begin
      // violation symbol; balanced, so disparity is unchanged.
      next_code = {run_disp, run_disp ? 10'h187 : 10'h278};
    end else if (!in_k) begin
      next_code = enc10(in_byte[4:0], in_byte[7:5], 1'b0, run_disp);
    end else if (in_byte[7:5] == 3'h0) begin
      next_code = enc10(`SLT_K28_CODE, in_byte[2:0], 1'b1, run_disp);
    end else if (in_byte[7:5] == 3'h1 && (in_byte[4:0] == 5'h17 || in_byte[4:0] == 5'h1B
             || in_byte[4:0] == 5'h1D || in_byte[4:0] == 5'h1E)) begin
      next_code = enc10(in_byte[4:0], 3'h7, 1'b1, run_disp);
    end else begin
      // Undefined special codes go out as violations rather than as silent data.
      next_code = {run_disp, run_disp ? 10'h187 : 10'h278};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_raw     <= 10'h000;
      in_byte    <= 8'h00;
      in_k       <= 1'b0;
      in_viol    <= 1'b0;
      in_pad     <= 1'b1;
      in_bypass  <= 1'b0;
      shifter    <= 10'h000;
      phase      <= 4'h0;
      run_disp   <= 1'b0;
      pad_active <= 1'b0;
      pad_count  <= 16'h0000;
    end else if (wclk_rise) begin
      shifter    <= next_code[9:0];
      if (!in_bypass || in_pad)
        run_disp <= next_code[10];
      pad_active <= in_pad;
      if (in_pad)
        pad_count <= pad_count + 16'h0001;
      phase      <= 4'h0;
      in_pad     <= ~load_en;
      in_bypass  <= bypass;
      if (load_en) begin
        in_raw  <= {kflag_s, byte_s, svs_s};
        in_byte <= byte_s;
        in_k    <= kflag_s;
        in_viol <= svs_s;
      end
    end else begin
      // one bit per clock, a first
      shifter <= {shifter[8:0], 1'b0};
      if (phase != `SLT_BITS_PER_CHAR)
        phase <= phase + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Read pulse and line drivers
  // ---------------------------------------------------------------
  // The pulse is timed from the local byte phase, so its low part is six of
  // every ten bit clocks only while the write clock runs at a tenth of pclk.
  // The enable is judged once per write clock edge, so an enable that moves
  // in mid-byte cannot cut or start a pulse part way through.
  reg         rp_arm;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_arm           <= 1'b0;
      read_pulse_out   <= 1'b1;
      line_pair_a_p    <= 1'b0;
      line_pair_a_n    <= 1'b1;
      line_pair_b_p    <= 1'b0;
      line_pair_b_n    <= 1'b1;
      monitor_pair_c_p <= 1'b0;
      monitor_pair_c_n <= 1'b1;
    end else begin
      if (wclk_rise)
        rp_arm <= ~ena_n_s;
      read_pulse_out   <= ~((wclk_rise & ~ena_n_s)
                            | (~wclk_rise & rp_arm & (phase < `SLT_RP_LOW_CYC - 4'h1)));
      // shared stream, A and B parked
      line_pair_a_p    <= ~foff_s & shifter[9];
      line_pair_a_n    <= foff_s | ~shifter[9];
      line_pair_b_p    <= ~foff_s & shifter[9];
      line_pair_b_n    <= foff_s | ~shifter[9];
      monitor_pair_c_p <= shifter[9];
      monitor_pair_c_n <= ~shifter[9];
    end
  end

endmodule // slt_transmitter

// *** slt_transmitter_props.sv ***
// Port checker for the serial link transmitter.
`timescale 1ns/100ps
`include "slt_regs.vh"
module slt_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pslverr,
  input wire logic        load_strobe_first_n,
  input wire logic        optical_force_off,
  input wire logic        read_pulse_out,
  input wire logic        line_pair_a_p,
  input wire logic        line_pair_a_n,
  input wire logic        line_pair_b_p,
  input wire logic        line_pair_b_n,
  input wire logic        monitor_pair_c_p,
  input wire logic        monitor_pair_c_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pair_b_copy_a: assert property ({line_pair_b_p, line_pair_b_n} ==
    {line_pair_a_p, line_pair_a_n}) else $error("pair b differs from pair a");
  pair_c_copy_a: assert property (!optical_force_off [*6] |->
    line_pair_a_p == monitor_pair_c_p) else $error("pair c differs from pair a");
  force_park_a: assert property (optical_force_off [*6] |->
    !line_pair_a_p && line_pair_a_n) else $error("pair a not parked");
  a_diff_a: assert property (line_pair_a_n != line_pair_a_p)
    else $error("pair a not differential");
  c_diff_a: assert property (monitor_pair_c_n != monitor_pair_c_p)
    else $error("pair c not differential");
  rp_width_a: assert property ($fell(read_pulse_out) |->
    !read_pulse_out [*6] ##1 read_pulse_out) else $error("read pulse width wrong");
  rp_idle_a: assert property (load_strobe_first_n [*8] ##1 load_strobe_first_n ##1
    load_strobe_first_n |-> read_pulse_out) else $error("read pulse without enable");
  slverr_map_a: assert property (psel && penable && paddr > `SLT_PADCNT_OFF |-> pslverr)
    else $error("unmapped access not refused");
  slverr_ok_a: assert property (psel && penable && paddr <= `SLT_PADCNT_OFF && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped access refused");
  cover property ($fell(read_pulse_out));
  cover property (optical_force_off [*6]);
  cover property (psel && penable && pslverr);
endmodule // slt_props

bind slt_transmitter slt_props chk_u (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .load_strobe_first_n, .optical_force_off, .read_pulse_out, .line_pair_a_p, .line_pair_a_n,
  .line_pair_b_p, .line_pair_b_n, .monitor_pair_c_p, .monitor_pair_c_n);

// *** slt_host_model.sv ***
// Host byte source that feeds the transmitter's parallel side.
`timescale 1ns/100ps
module slt_host_model (
  input  wire logic  pclk,
  input  wire logic  presetn,
  output logic       write_clock,
  output logic       load_strobe_first_n,
  output logic       load_gate_next_n,
  output logic       char_kind_flag,
  output logic       violation_send,
  output logic [7:0] byte_in
);
  logic [10:0] q[$];
  logic [10:0] w;
  logic [3:0]  ph;
  task automatic push(input logic [10:0] v);
    q.push_back(v);
  endtask
  // Inputs change mid-period so they are stable around each write clock rise.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 4'h0;
      write_clock <= 1'b0;
      {load_strobe_first_n, load_gate_next_n} <= 2'h3;
      {char_kind_flag, violation_send, byte_in} <= 10'h000;
    end else begin
      ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
      write_clock <= (ph < 4'h5);
      if (ph == 4'h5) begin
        if (q.size() > 0) begin
          w = q.pop_front();
          // host presents kind, violation and byte together
          load_strobe_first_n <= !w[10];
          load_gate_next_n <= w[10];
          {char_kind_flag, violation_send, byte_in} <= w[9:0];
        end else begin
          {load_strobe_first_n, load_gate_next_n} <= 2'h3;
          byte_in <= ~byte_in;
        end
      end
    end
  end
endmodule // slt_host_model

// *** serial_link_transmitter_tb_top.sv ***
// Self-checking testbench for the serial link transmitter.
`timescale 1ns/100ps
`include "slt_regs.vh"
module serial_link_transmitter_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        write_clock, load_strobe_first_n, load_gate_next_n, char_kind_flag;
  logic        violation_send, optical_force_off, read_pulse_out;
  logic [7:0]  byte_in;
  logic        line_pair_a_p, line_pair_a_n, line_pair_b_p, line_pair_b_n;
  logic        monitor_pair_c_p, monitor_pair_c_n;
  logic [19:0] sc;
  int          fails, compares;
  slt_transmitter dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .write_clock, .load_strobe_first_n, .load_gate_next_n, .char_kind_flag,
    .violation_send, .byte_in, .optical_force_off, .read_pulse_out, .line_pair_a_p,
    .line_pair_a_n, .line_pair_b_p, .line_pair_b_n, .monitor_pair_c_p, .monitor_pair_c_n);
  slt_host_model host_u (.pclk, .presetn, .write_clock, .load_strobe_first_n,
    .load_gate_next_n, .char_kind_flag, .violation_send, .byte_in);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) sc <= {sc[18:0], monitor_pair_c_p};
  task automatic summarize;
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // Searches the monitor stream, so an alias of either disparity form is accepted.
  task automatic cmp_code(input logic [19:0] p0, input logic [19:0] p1, input int n);
    logic [19:0] m;
    m = 20'hFFFFF >> (20 - n);
    compares++;
    for (int i = 0; i < 300; i++) begin
      @(posedge pclk);
      #1;
      if ((sc & m) === p0 || (sc & m) === p1) return;
    end
    fails++;
    $display("MISMATCH %0t code %h not seen", $time, p0);
    summarize();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      $display("MISMATCH %0t bus answer never came", $time);
      summarize();
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  // Waits for one read pulse and counts its low bit clocks.
  task automatic cmp_pulse;
    int n;
    int low;
    n = 0;
    low = 0;
    while (read_pulse_out !== 1'b0 && n < 100) begin
      @(posedge pclk);
      #1;
      n++;
    end
    while (read_pulse_out === 1'b0 && low < 20) begin
      @(posedge pclk);
      #1;
      low++;
    end
    cmp_val(low, {28'h0, `SLT_RP_LOW_CYC});
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, `SLT_CTRL_OFF, 32'h0);
    cmp_val(r, `SLT_CTRL_RST);
    apb(1'b0, 12'h00C, 32'h0);
    cmp_val(r, 32'h0);
    cmp_val({31'h0, e}, 32'h1);
  endtask
  task automatic t_chars;
    cmp_code(20'h3EB05, 20'hC14FA, 20);
    host_u.push(11'h4B5);
    cmp_pulse();
    cmp_code(20'h002AA, 20'h002AA, 10);
    host_u.push(11'h207);
    cmp_code(20'h000F8, 20'h00307, 10);
    host_u.push(11'h500);
    cmp_code(20'h00278, 20'h00187, 10);
    host_u.push(11'h2E0);
    cmp_code(20'h00278, 20'h00187, 10);
  endtask
  task automatic t_bypass;
    apb(1'b1, `SLT_CTRL_OFF, 32'h1);
    apb(1'b0, `SLT_CTRL_OFF, 32'h0);
    cmp_val(r, 32'h1);
    host_u.push(11'h65A);
    cmp_code(20'h002B4, 20'h002B4, 10);
    apb(1'b1, `SLT_CTRL_OFF, 32'h0);
  endtask
  task automatic t_force;
    optical_force_off <= 1'b1;
    repeat (8) @(posedge pclk);
    cmp_val({line_pair_a_p, line_pair_a_n, line_pair_b_p, line_pair_b_n}, 32'h5);
    cmp_code(20'h000FA, 20'h00305, 10);
    apb(1'b0, `SLT_STATUS_OFF, 32'h0);
    cmp_val(r & 32'hFFFFFFFC, 32'h4);
    apb(1'b0, `SLT_PADCNT_OFF, 32'h0);
    cmp_val({15'h0, r[31:16], |r[15:0]}, 32'h1);
    optical_force_off <= 1'b0;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, optical_force_off} = '0;
    fails = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_chars();
    t_bypass();
    t_force();
    summarize();
  end
endmodule // serial_link_transmitter_tb_top
